// ==== inc/hwcfg_pkg.sv ====
// Constants for the hardware configuration register bank.
// Assumes a byte-addressed register port with 32-bit data.
package hwcfg_pkg;
   localparam int unsigned AW = 12;
   localparam logic [11:0] OFF_HARDWARE_CONFIGURATION   = 12'h010;
   localparam logic [11:0] OFF_IRQ_STS  = 12'h100;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h104;
   localparam logic [11:0] OFF_IMAGE    = 12'h108;
   localparam logic [11:0] OFF_STATUS   = 12'h10c;
   // Field positions in the configuration register
   localparam int unsigned B_FULL_SOFTWARE_RESET   = 0;
   localparam int unsigned B_LITE_SOFTWARE_RESET   = 1;
   localparam int unsigned B_ETC    = 3;
   localparam int unsigned B_MEF    = 4;
   localparam int unsigned B_POL    = 5;
   localparam int unsigned B_SEL_LO = 6;
   localparam int unsigned B_SEL_HI = 7;
   localparam int unsigned B_PROT   = 12;
   localparam int unsigned B_DSRC   = 13;
   localparam int unsigned B_NDSTS  = 15;
   localparam int unsigned B_REF25  = 24;
   localparam int unsigned B_GEN125 = 25;
   // Image bits: [0] gen125 [1] ref25 [2] polarity [4:3] select
   localparam int unsigned I_GEN125 = 0;
   localparam int unsigned I_REF25  = 1;
   localparam int unsigned I_POL    = 2;
   localparam int unsigned I_SEL_LO = 3;
   localparam int unsigned I_SEL_HI = 4;
   localparam int unsigned IMG_W    = 5;
   // Interrupt status bits
   localparam int unsigned Q_TO   = 0;
   localparam int unsigned Q_LDN  = 1;
   localparam int unsigned Q_SDN  = 2;
   localparam int unsigned NIRQ   = 3;
   localparam logic [1:0] SEL_L2   = 2'h0;
   localparam logic [1:0] SEL_L1   = 2'h1;
   localparam logic [1:0] SEL_L0   = 2'h2;
   localparam logic [1:0] SEL_L3   = 2'h3;
   // Timing
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned TO_LONG_MS  = 30;
   localparam int unsigned TO_SHORT_PS = 1_280_000;
   localparam int unsigned TO_LONG_CYC = TO_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned TO_SHORT_CYC = TO_SHORT_PS / 10_000;
   localparam int unsigned RST_CYC     = 16;
   localparam int unsigned PHY_HOLD_CYC = 32;
endpackage : hwcfg_pkg

// ==== src/hwcfg_regs.sv ====
// Hardware configuration register, lower fields, with soft resets and
// EEPROM timeout timing. Assumes one 100 MHz clock and a strobe-based port.
// Summary of operation
// - Descriptor-source bit picks register defaults or descriptor RAM without EEPROM.
// - Descriptor-source bit ignored when EEPROM present or OTP configured.
// - Protect bit keeps marked fields through all resets except power-on.
// - Suspend select 00 L2, 01 adds L1 and detach, 10 adds L0, 11 L3.
// - Suspend select and polarity act regardless of source bit or EEPROM.
// - Polarity clear drives suspend pin low when asserted, set drives high.
// - Multi-frame bit allows packing several frames per USB transmit packet.
// - EEPROM timeout after 30 ms, or 1.28 us when timeout select set.
// - EEPROM timeout sets timeout flag in EEPROM command register.
// - Writing one starts lite reset; bit self-clears when sequence completes.
// - Lite reset keeps USB controller, PHY connection and EEPROM contents.
// - Writing one starts full reset with EEPROM reload; bit self-clears.
// - Full reset holds PHY disconnected, then releases it after re-initialisation.
// - Clock enables default from EEPROM, then OTP, else zero.
// - USB or lite reset restores loaded fields from last image or default.
// - Suspend select loads from EEPROM, OTP, else 00; reverts on resets.
// - Polarity loads from EEPROM, OTP, else 0; reverts on resets.
// - Net-detach status powers up set only if a detach event occurred.
`timescale 1ns/1ps
module hwcfg_regs
   import hwcfg_pkg::*;
#(
   parameter int unsigned TO_LONG = TO_LONG_CYC
)
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   // Register port
   input  wire logic [AW-1:0]     addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [31:0]       rdata_o,
   // Configuration sources
   input  wire logic              eeprom_present_i,
   input  wire logic              otp_config_i,
   input  wire logic [IMG_W-1:0]  eeprom_image_i,
   input  wire logic [IMG_W-1:0]  otp_image_i,
   input  wire logic              usb_reset_i,
   input  wire logic              net_detach_event_i,
   // Power state levels, same clock
   input  wire logic [3:0]        suspend_level_i,
   input  wire logic              net_detach_state_i,
   // EEPROM controller
   input  wire logic              eeprom_busy_i,
   input  wire logic              eeprom_resp_i,
   output logic                   eeprom_timeout_flag_o,
   // Device controls
   output logic                   suspend_pin_o,
   output logic                   use_descriptor_ram_o,
   output logic                   multi_frame_packing_enable_o,
   output logic                   gen_125mhz_enable_o,
   output logic                   ref_25mhz_out_enable_o,
   output logic                   lite_reset_o,
   output logic                   full_reset_o,
   output logic                   eeprom_reload_o,
   output logic                   phy_disconnect_o,
   output logic                   irq_o
);
   typedef enum logic [1:0] {S_IDLE, S_LITE, S_FULL, S_PHY} hwcfg_state_t;

   hwcfg_state_t   state_reg, state_next;
   logic [15:0]    seq_cnt_reg;
   logic [24:0]    to_cnt_reg;
   logic           por_done_reg;
   logic [IMG_W-1:0] image_reg;
   logic           dsrc_reg, prot_reg, mef_reg, etc_reg, pol_reg, gen_reg, ref_reg;
   logic [1:0]     sel_reg;
   logic           ndsts_reg;
   logic           lite_software_reset_bit_reg, full_software_reset_bit_reg;
   logic [NIRQ-1:0] sts_reg, mask_reg;
   logic           to_reg;

   wire wr_cfg   = wr_i && addr_i == OFF_HARDWARE_CONFIGURATION;
   wire wr_sts   = wr_i && addr_i == OFF_IRQ_STS;
   wire wr_mask  = wr_i && addr_i == OFF_IRQ_MASK;
   wire go_lite  = wr_cfg && wdata_i[B_LITE_SOFTWARE_RESET] && state_reg == S_IDLE;
   wire go_full  = wr_cfg && wdata_i[B_FULL_SOFTWARE_RESET] && state_reg == S_IDLE;
   wire seq_end  = seq_cnt_reg == 16'(RST_CYC - 1);
   wire phy_end  = seq_cnt_reg == 16'(PHY_HOLD_CYC - 1);
   wire lite_done = state_reg == S_LITE && seq_end;
   wire full_done = state_reg == S_PHY && phy_end;
   // Image selection: EEPROM first, then OTP, else zero
   wire [IMG_W-1:0] src_image = eeprom_present_i ? eeprom_image_i :
                                otp_config_i     ? otp_image_i : '0;
   wire load_image = state_reg == S_FULL && seq_end;
   // Restore from last image on USB or lite reset; protect keeps fields
   wire restore    = (usb_reset_i || lite_done) && !prot_reg;
   wire reload     = load_image && !prot_reg;
   // The power-on load must take the sources directly: image_reg is still empty then
   wire [IMG_W-1:0] new_img = (load_image || !por_done_reg) ? src_image : image_reg;
   wire to_limit_hit = to_cnt_reg == (etc_reg ? 25'(TO_SHORT_CYC - 1)
                                               : 25'(TO_LONG - 1));
   wire timeout_pulse = eeprom_busy_i && !eeprom_resp_i && to_limit_hit && !to_reg;
   // Suspend request by select field
   wire susp_req = suspend_level_i[2]
                 | ((sel_reg != SEL_L2) & (suspend_level_i[1] | net_detach_state_i))
                 | (((sel_reg == SEL_L0) | (sel_reg == SEL_L3)) & suspend_level_i[0])
                 | ((sel_reg == SEL_L3) & suspend_level_i[3]);
   // Descriptor RAM only when no EEPROM and no OTP
   wire use_ram = dsrc_reg && !eeprom_present_i && !otp_config_i;
   wire [NIRQ-1:0] ev = {full_done, lite_done, timeout_pulse};
   wire irq_pend = |(sts_reg & mask_reg);
   wire [31:0] cfg_rd = {6'h0, gen_reg, ref_reg, 8'h0, ndsts_reg, 1'b0, dsrc_reg,
                         prot_reg, 4'h0, sel_reg, pol_reg, mef_reg, etc_reg, 1'b0,
                         lite_software_reset_bit_reg, full_software_reset_bit_reg};
   wire [31:0] rd_mux = addr_i == OFF_HARDWARE_CONFIGURATION   ? cfg_rd :
                        addr_i == OFF_IRQ_STS  ? {29'h0, sts_reg} :
                        addr_i == OFF_IRQ_MASK ? {29'h0, mask_reg} :
                        addr_i == OFF_IMAGE    ? {27'h0, image_reg} :
                        addr_i == OFF_STATUS   ? {30'h0, state_reg} : 32'h0;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: if (go_full) state_next = S_FULL; else if (go_lite) state_next = S_LITE;
         S_LITE: if (seq_end) state_next = S_IDLE;
         S_FULL: if (seq_end) state_next = S_PHY;
         S_PHY:  if (phy_end) state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_reg   <= S_IDLE;
         seq_cnt_reg <= 16'h0;
      end
      else
      begin
         state_reg   <= state_next;
         seq_cnt_reg <= (state_next != state_reg || state_reg == S_IDLE) ? 16'h0
                                                                         : seq_cnt_reg + 16'h1;
      end
   end

   // Image is captured from sources once after power-on, then on full reset
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         por_done_reg <= 1'b0;
         image_reg    <= '0;
         ndsts_reg    <= 1'b0;
      end
      else
      begin
         por_done_reg <= 1'b1;
         if (!por_done_reg || load_image)
            image_reg <= src_image;
         if (!por_done_reg)
            ndsts_reg <= net_detach_event_i;
         else if (net_detach_event_i)
            ndsts_reg <= 1'b1;
         else if (wr_cfg && wdata_i[B_NDSTS])
            ndsts_reg <= 1'b0;
      end
   end

   // Image-loaded fields
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         gen_reg <= 1'b0;
         ref_reg <= 1'b0;
         pol_reg <= 1'b0;
         sel_reg <= 2'h0;
      end
      else if (!por_done_reg || restore || reload)
      begin
         gen_reg <= new_img[I_GEN125];
         ref_reg <= new_img[I_REF25];
         pol_reg <= new_img[I_POL];
         sel_reg <= new_img[I_SEL_HI:I_SEL_LO];
      end
      else if (wr_cfg)
      begin
         gen_reg <= wdata_i[B_GEN125];
         ref_reg <= wdata_i[B_REF25];
         pol_reg <= wdata_i[B_POL];
         sel_reg <= wdata_i[B_SEL_HI:B_SEL_LO];
      end
   end

   // Plain fields; protected ones survive soft resets
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         dsrc_reg <= 1'b0;
         prot_reg <= 1'b0;
         mef_reg  <= 1'b0;
         etc_reg  <= 1'b0;
      end
      else
      begin
         if (restore || reload)
         begin
            dsrc_reg <= 1'b0;
            prot_reg <= 1'b0;
         end
         else if (wr_cfg)
         begin
            dsrc_reg <= wdata_i[B_DSRC];
            prot_reg <= wdata_i[B_PROT];
         end
         if (usb_reset_i || lite_done || load_image)
         begin
            mef_reg <= 1'b0;
            etc_reg <= 1'b0;
         end
         else if (wr_cfg)
         begin
            mef_reg <= wdata_i[B_MEF];
            etc_reg <= wdata_i[B_ETC];
         end
      end
   end

   // Self-clearing reset bits; a written zero changes nothing
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         lite_software_reset_bit_reg <= 1'b0;
         full_software_reset_bit_reg <= 1'b0;
      end
      else
      begin
         lite_software_reset_bit_reg <= go_lite && !go_full ? 1'b1 : (lite_done ? 1'b0 : lite_software_reset_bit_reg);
         full_software_reset_bit_reg <= go_full ? 1'b1 : (full_done ? 1'b0 : full_software_reset_bit_reg);
      end
   end

   // EEPROM response timer and flag; flag drops when eeprom_busy_i goes low
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         to_cnt_reg <= 25'h0;
         to_reg     <= 1'b0;
      end
      else
      begin
         to_cnt_reg <= (!eeprom_busy_i || eeprom_resp_i || to_limit_hit) ? 25'h0
                                                                          : to_cnt_reg + 25'h1;
         if (timeout_pulse)
            to_reg <= 1'b1;
         else if (!eeprom_busy_i)
            to_reg <= 1'b0;
      end
   end

   // Interrupts: set wins over write-one-to-clear
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sts_reg  <= '0;
         mask_reg <= '0;
         irq_o    <= 1'b0;
      end
      else
      begin
         sts_reg  <= ev | (sts_reg & ~(wr_sts ? wdata_i[NIRQ-1:0] : '0));
         if (wr_mask)
            mask_reg <= wdata_i[NIRQ-1:0];
         irq_o    <= irq_pend;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rdata_o                      <= 32'h0;
         suspend_pin_o                <= 1'b1;
         use_descriptor_ram_o         <= 1'b0;
         multi_frame_packing_enable_o <= 1'b0;
         gen_125mhz_enable_o          <= 1'b0;
         ref_25mhz_out_enable_o       <= 1'b0;
         lite_reset_o                 <= 1'b0;
         full_reset_o                 <= 1'b0;
         eeprom_reload_o              <= 1'b0;
         phy_disconnect_o             <= 1'b0;
         eeprom_timeout_flag_o        <= 1'b0;
      end
      else
      begin
         rdata_o                      <= rd_i ? rd_mux : 32'h0;
         suspend_pin_o                <= susp_req ~^ pol_reg;
         use_descriptor_ram_o         <= use_ram;
         multi_frame_packing_enable_o <= mef_reg;
         gen_125mhz_enable_o          <= gen_reg;
         ref_25mhz_out_enable_o       <= ref_reg;
         lite_reset_o                 <= state_next == S_LITE;
         full_reset_o                 <= state_next == S_FULL;
         eeprom_reload_o              <= load_image;
         phy_disconnect_o             <= state_next == S_FULL || state_next == S_PHY;
         eeprom_timeout_flag_o        <= to_reg;
      end
   end

   // Full reset: disconnect checked high for 8 cycles, starting two cycles after the write
   sequence full_start_seq;
      go_full;
   endsequence
   sequence full_hold_seq;
      ##1 phy_disconnect_o [*8];
   endsequence

   chk_lite_self_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
      go_lite && !go_full |=> lite_software_reset_bit_reg [*8]) else $error("lite bit cleared early");
   chk_lite_bit_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
      lite_done |=> !lite_software_reset_bit_reg) else $error("lite bit stuck");
   chk_full_phy_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
      full_start_seq |=> full_hold_seq) else $error("phy not disconnected");
   chk_reload_single: assert property (@(posedge clk_i) disable iff (!resetn_i)
      eeprom_reload_o |=> !eeprom_reload_o) else $error("reload pulse too long");
   chk_lite_no_phy: assert property (@(posedge clk_i) disable iff (!resetn_i)
      state_reg == S_LITE |-> !eeprom_reload_o && !full_reset_o && !phy_disconnect_o)
      else $error("lite touched usb");
   chk_timeout_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
      timeout_pulse |=> ##1 eeprom_timeout_flag_o) else $error("timeout flag missing");
   chk_dsrc_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
      eeprom_present_i |=> !use_descriptor_ram_o) else $error("descriptor ram with eeprom");
   chk_susp_l2: assert property (@(posedge clk_i) disable iff (!resetn_i)
      suspend_level_i[2] |=> suspend_pin_o == $past(pol_reg))
      else $error("suspend not asserted");
   chk_mef_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ##1 multi_frame_packing_enable_o == $past(mef_reg)) else $error("mef mismatch");
   chk_irq_level: assert property (@(posedge clk_i) disable iff (!resetn_i)
      ##1 irq_o == $past(irq_pend)) else $error("irq level wrong");
   chk_protect_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
      prot_reg && lite_done |=> prot_reg) else $error("protected bit lost");
endmodule : hwcfg_regs

// ==== test/hwcfg_regs_tb.sv ====
// Self-checking bench for the hardware configuration register bank.
// Assumes the design reports its own assertions; the bench drives every port.
`timescale 1ns/1ps
module hwcfg_regs_tb
   import hwcfg_pkg::*;
;
   localparam int unsigned TOL = 200;
   logic            clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [AW-1:0]   addr_i = 12'h000;
   logic [31:0]     wdata_i = 32'h0, rdata_o, rd_val;
   logic            eeprom_present_i = 1'b1, otp_config_i = 1'b0, usb_reset_i = 1'b0;
   logic [IMG_W-1:0] eeprom_image_i = 5'h16, otp_image_i = 5'h09;
   logic            net_detach_event_i = 1'b1, net_detach_state_i = 1'b0;
   logic [3:0]      suspend_level_i = 4'h0;
   logic            eeprom_busy_i = 1'b0, eeprom_resp_i = 1'b0;
   logic            to_flag, susp, dram, multi_frame_packing_enable, g125, r25, lite_software_reset, frst, reload, phyd, irq;
   int              failures = 0, tests_run = 0, reload_cnt = 0, phy_cnt = 0, lite_software_reset_cnt = 0;

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      reload_cnt <= reload_cnt + (reload === 1'b1);
      phy_cnt    <= phy_cnt + (phyd === 1'b1);
      lite_software_reset_cnt   <= lite_software_reset_cnt + (lite_software_reset === 1'b1);
   end

   hwcfg_regs #(.TO_LONG(TOL)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .eeprom_present_i(eeprom_present_i), .otp_config_i(otp_config_i),
      .eeprom_image_i(eeprom_image_i), .otp_image_i(otp_image_i), .usb_reset_i(usb_reset_i),
      .net_detach_event_i(net_detach_event_i), .suspend_level_i(suspend_level_i),
      .net_detach_state_i(net_detach_state_i), .eeprom_busy_i(eeprom_busy_i),
      .eeprom_resp_i(eeprom_resp_i), .eeprom_timeout_flag_o(to_flag), .suspend_pin_o(susp),
      .use_descriptor_ram_o(dram), .multi_frame_packing_enable_o(multi_frame_packing_enable),
      .gen_125mhz_enable_o(g125), .ref_25mhz_out_enable_o(r25), .lite_reset_o(lite_software_reset),
      .full_reset_o(frst), .eeprom_reload_o(reload), .phy_disconnect_o(phyd), .irq_o(irq));

   task automatic tally_and_finish;
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rd_val = rdata_o;
   endtask : rd

   // Config word as loaded from a five-bit image
   function automatic logic [31:0] cfg_of(input logic [4:0] img, input logic nd);
      return {6'h00, img[0], img[1], 8'h00, nd, 7'h00, img[4:3], img[2], 5'h00};
   endfunction : cfg_of

   task automatic do_reset(input logic pres, input logic otp);
      @(posedge clk_i);
      resetn_i <= 1'b0; eeprom_present_i <= pres; otp_config_i <= otp;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
   endtask : do_reset

   // Poll until a self-clearing bit drops; bounded
   task automatic wait_clear(input int b);
      for (int n = 0; n < 100; n++)
      begin
         rd(OFF_HARDWARE_CONFIGURATION);
         if (rd_val[b] === 1'b0) return;
      end
      check(32'h1, 32'h0);
      tally_and_finish;
   endtask : wait_clear

   task automatic t_defaults;
      do_reset(1'b0, 1'b1);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val, cfg_of(otp_image_i, 1'b1));
      rd(OFF_IMAGE); check(rd_val, {27'h0, otp_image_i});
      do_reset(1'b0, 1'b0);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val, cfg_of(5'h00, 1'b1));
      net_detach_event_i <= 1'b0;
      do_reset(1'b1, 1'b1);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val, cfg_of(eeprom_image_i, 1'b0));
      check({g125, r25}, {eeprom_image_i[0], eeprom_image_i[1]});
   endtask : t_defaults

   task automatic t_suspend;
      logic a, e;
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 2; p++)
            for (int lv = 0; lv < 32; lv++)
            begin
               suspend_level_i <= lv[3:0]; net_detach_state_i <= lv[4];
               eeprom_present_i <= lv[0];
               wr(OFF_HARDWARE_CONFIGURATION, {24'h0, s[1:0], p[0], 5'h00} | (32'h2000 & {32{lv[1]}}));
               repeat (2) @(posedge clk_i);
               #1;
               a = lv[2] | (s != 0 && (lv[1] | lv[4])) | (s[1] & lv[0]) | (s == 3 && lv[3]);
               e = a ? p[0] : ~p[0];
               check(susp, e);
            end
   endtask : t_suspend

   task automatic t_source;
      eeprom_present_i <= 1'b0; otp_config_i <= 1'b0;
      wr(OFF_HARDWARE_CONFIGURATION, 32'h2010);
      repeat (2) @(posedge clk_i);
      check({dram, multi_frame_packing_enable}, 2'b11);
      otp_config_i <= 1'b1;
      wr(OFF_HARDWARE_CONFIGURATION, 32'h2000);
      repeat (2) @(posedge clk_i);
      check({dram, multi_frame_packing_enable}, 2'b00);
      otp_config_i <= 1'b0; eeprom_present_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check(dram, 1'b0);
   endtask : t_source

   task automatic t_timeout(input logic eeprom_timeout_select, input int lim);
      wr(OFF_HARDWARE_CONFIGURATION, {28'h0, eeprom_timeout_select, 3'h0});
      // An answer just before the limit, with busy then dropped, must not raise the flag
      eeprom_busy_i <= 1'b1;
      repeat (lim - 10) @(posedge clk_i);
      eeprom_resp_i <= 1'b1;
      @(posedge clk_i);
      eeprom_resp_i <= 1'b0;
      eeprom_busy_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      check(to_flag, 1'b0);
      @(posedge clk_i);
      eeprom_busy_i <= 1'b1;
      repeat (lim - 20) @(posedge clk_i);
      check(to_flag, 1'b0);
      repeat (40) @(posedge clk_i);
      check(to_flag, 1'b1);
      rd(OFF_IRQ_STS); check(rd_val[Q_TO], 1'b1);
      wr(OFF_IRQ_MASK, 32'h0); repeat (2) @(posedge clk_i);
      check(irq, 1'b0);
      wr(OFF_IRQ_MASK, 32'h7); repeat (2) @(posedge clk_i);
      check(irq, 1'b1);
      eeprom_busy_i <= 1'b0;
      wr(OFF_IRQ_STS, 32'h1);
      repeat (2) @(posedge clk_i);
      rd(OFF_IRQ_STS); check({to_flag, rd_val[Q_TO], irq}, 3'b000);
      wr(OFF_IRQ_MASK, 32'h0);
   endtask : t_timeout

   task automatic t_lite(input logic prot);
      int r0, p0, l0;
      wr(OFF_HARDWARE_CONFIGURATION, {19'h0, prot, 4'h0, 2'h3, ~eeprom_image_i[2], 5'h0});
      wr(OFF_HARDWARE_CONFIGURATION, 32'h0); check({lite_software_reset, frst}, 2'b00);
      r0 = reload_cnt; p0 = phy_cnt; l0 = lite_software_reset_cnt;
      wr(OFF_HARDWARE_CONFIGURATION, {19'h0, prot, 4'h0, 2'h3, ~eeprom_image_i[2], 3'h0, 2'h2});
      check(lite_software_reset, 1'b1);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val[B_LITE_SOFTWARE_RESET], 1'b1);
      wait_clear(B_LITE_SOFTWARE_RESET);
      check(lite_software_reset, 1'b0);
      check(lite_software_reset_cnt - l0, RST_CYC);
      check(reload_cnt - r0, 0);
      check(phy_cnt - p0, 0);
      check(rd_val[B_PROT], prot);
      check(rd_val[7:5], prot ? {2'h3, ~eeprom_image_i[2]} : eeprom_image_i[4:2]);
      rd(OFF_IRQ_STS); check(rd_val[Q_LDN], 1'b1);
      wr(OFF_IRQ_STS, 32'h2);
   endtask : t_lite

   task automatic t_usb;
      wr(OFF_HARDWARE_CONFIGURATION, 32'h10e0);
      @(posedge clk_i); usb_reset_i <= 1'b1;
      @(posedge clk_i); usb_reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val[12:5], 8'h87);
      wr(OFF_HARDWARE_CONFIGURATION, 32'h00e0);
      @(posedge clk_i); usb_reset_i <= 1'b1;
      @(posedge clk_i); usb_reset_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val[7:5], eeprom_image_i[4:2]);
   endtask : t_usb

   task automatic t_full;
      int r0, p0;
      r0 = reload_cnt; p0 = phy_cnt;
      wr(OFF_HARDWARE_CONFIGURATION, 32'h00e1);
      check({frst, phyd}, 2'b11);
      rd(OFF_HARDWARE_CONFIGURATION); check(rd_val[B_FULL_SOFTWARE_RESET], 1'b1);
      wait_clear(B_FULL_SOFTWARE_RESET);
      check({frst, phyd}, 2'b00);
      check(reload_cnt - r0, 1);
      check(phy_cnt - p0, RST_CYC + PHY_HOLD_CYC);
      check(rd_val[7:5], eeprom_image_i[4:2]);
      rd(OFF_IRQ_STS); check(rd_val[Q_SDN], 1'b1);
      wr(OFF_IRQ_STS, 32'h4);
   endtask : t_full

   initial
   begin
      fork
         begin
            t_defaults;
            t_source;
            t_suspend;
            t_timeout(1'b1, TO_SHORT_CYC);
            t_timeout(1'b0, TOL);
            t_lite(1'b0);
            t_lite(1'b1);
            t_usb;
            t_full;
         end
         begin
            repeat (60000) @(posedge clk_i);
            failures++;
         end
      join_any
      tally_and_finish;
   end
endmodule : hwcfg_regs_tb
